// ---- rtl/cas_pkg.sv ----
// Purpose: shared constants and types for the caller alert status and interrupt block
// Assumes: single 40 MHz clock, all inputs synchronous
// Notes: register bit positions follow the device's status, interrupt and mode registers
package cas_pkg;
    // mode register one bits
    localparam int MD1_FSK_EN = 7;
    localparam int MD1_BOM_MASK = 6;
    localparam int MD1_POL_EN = 4;
    localparam int MD1_IRQ_LOW = 3;
    // mode register two bits
    localparam int MD2_SYSCLK_EN = 7;
    localparam int MD2_TB_EN = 6;
    localparam int MD2_SEC_SEL = 5;
    // status register bits
    localparam int ST_POL_A = 7;
    localparam int ST_POL_B = 6;
    localparam int ST_BATT = 5;
    localparam int ST_BOM = 4;
    localparam int ST_OVR = 3;
    localparam int ST_FRM = 2;
    // interrupt register bits
    localparam int IF_MIN = 7;
    localparam int IF_SEC = 6;
    localparam int IF_FSK = 5;
    localparam int IF_LOWLVL = 4;
    localparam int IF_TONE = 1;
    localparam int IF_POL = 0;
    // reset and saturation values
    localparam logic [7:0] RING_RESET = 8'hff;
    localparam logic [7:0] RING_MAX = 8'hff;
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int TICK_HZ = 2048;
    localparam int TICK_CYC = CLK_HZ / TICK_HZ;
    localparam int LVL_MS = 8;
    localparam int LVL_CYC = CLK_HZ / 1000 * LVL_MS;
    localparam int SEC_TICKS = 2048;
    localparam int MIN_SECS = 60;
    localparam int INIT_CLKS = 100;
    localparam int SYS_HZ = 3580000;
    localparam int INIT_CYC = (INIT_CLKS * (CLK_HZ / 1000) + SYS_HZ / 1000 - 1)
        / (SYS_HZ / 1000);
    // received word from demodulator
    typedef struct packed {
        logic valid;
        logic start_ok;
        logic stop_ok;
        logic [7:0] data;
    } cas_rx_word_t;
    // one-hot ring sequence states
    typedef enum logic [2:0] {
        RS_IDLE = 3'b001,
        RS_B_SEEN = 3'b010,
        RS_A_SEEN = 3'b100
    } cas_ring_state_t;
endpackage : cas_pkg

// ---- rtl/cas_alert_status.sv ----
// Purpose: status flags, event flags, ring period and interrupt output
// Assumes: demodulators and the serial slave sit outside; inputs synchronous to mclk_i
// Notes: interrupt flags clear on read; an event in the read cycle survives
`timescale 1ns/100ps
module cas_alert_status
    import cas_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYC,
    parameter int LVL_DIV = LVL_CYC,
    parameter int SEC_LEN = SEC_TICKS
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // mode bits
    input wire logic [7:0] mode_reg_one_i,
    input wire logic [7:0] mode_reg_two_i,
    // comparators
    input wire logic polarity_in_a_i,
    input wire logic polarity_in_b_i,
    input wire logic battery_sense_input_i,
    // detectors
    input wire logic tone_enable_i,
    input wire logic tone_detect_i,
    input wire logic level_low_i,
    input wire logic begin_of_marks_i,
    input wire cas_rx_word_t rx_word_i,
    // host read side
    input wire logic int_read_i,
    input wire logic int_first_bit_i,
    input wire logic serial_clk_rise_i,
    // outputs
    output logic [7:0] status_o,
    output logic [7:0] interrupt_flag_reg_o,
    output logic [7:0] ring_period_o,
    output logic [7:0] rx_data_o,
    output logic tone_init_busy_o,
    output logic irq_o,
    output logic irq_oe_o
);
    localparam int TICK_W = $clog2(TICK_DIV);
    localparam int INIT_W = $clog2(INIT_CYC + 1);
    localparam logic [TICK_W-1:0] TICK_MAX = TICK_W'(TICK_DIV - 1);
    localparam logic [19:0] LVL_MAX = 20'(LVL_DIV - 1);
    localparam logic [11:0] SEC_MAX = 12'(SEC_LEN - 1);
    localparam logic [5:0] MIN_MAX = 6'(MIN_SECS - 1);
    localparam logic [INIT_W-1:0] INIT_MAX = INIT_W'(INIT_CYC);

    logic [7:0] status_reg, status_next;
    logic [7:0] flag_reg, flag_next;
    logic [7:0] ring_reg, ring_next;
    logic [7:0] rx_data_reg;
    logic [7:0] meas_reg, meas_next;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic [19:0] lvl_cnt_reg;
    logic [11:0] sec_cnt_reg;
    logic [5:0] min_cnt_reg;
    logic [INIT_W-1:0] init_cnt_reg;
    logic tone_en_d_reg;
    logic irq_reg, irq_oe_reg;
    logic blank_reg;
    cas_ring_state_t ring_state_reg, ring_state_next;

    // polarity events
    wire pol_a_now = ~polarity_in_a_i;
    wire pol_b_now = polarity_in_b_i;
    wire edge_a = status_reg[ST_POL_A] & ~pol_a_now;
    wire edge_b = ~status_reg[ST_POL_B] & pol_b_now;
    wire pol_en = mode_reg_one_i[MD1_POL_EN];
    // ring sequence only counts edges that really interrupt
    wire ev_a = pol_en & edge_a;
    wire ev_b = pol_en & edge_b;
    wire ev_pol = ev_a | ev_b;

    // ring period measurement
    wire tick = (tick_cnt_reg == TICK_MAX);
    wire meas_sat = (meas_reg == RING_MAX);

    // receiver
    wire fsk_en = mode_reg_one_i[MD1_FSK_EN];
    wire bom_mask = mode_reg_one_i[MD1_BOM_MASK];
    wire bom_ok = ~bom_mask | status_reg[ST_BOM];
    wire word_good = rx_word_i.valid & rx_word_i.start_ok & rx_word_i.stop_ok;
    wire word_bad = rx_word_i.valid & ~(rx_word_i.start_ok & rx_word_i.stop_ok);
    wire ev_fsk = fsk_en & bom_ok & word_good;
    wire overrun = ev_fsk & flag_reg[IF_FSK];

    // tone detector
    wire tone_en = tone_enable_i & mode_reg_two_i[MD2_SYSCLK_EN];
    wire ev_tone = tone_en & ~tone_init_busy_o & tone_detect_i & ~level_low_i;

    // level sample and time base
    wire lvl_sample = (lvl_cnt_reg == LVL_MAX);
    wire tb_en = mode_reg_two_i[MD2_TB_EN];
    wire sec_sel = mode_reg_two_i[MD2_SEC_SEL];
    wire sec_wrap = tb_en & tick & (sec_cnt_reg == SEC_MAX);
    wire min_wrap = sec_wrap & (min_cnt_reg == MIN_MAX);
    wire ev_sec = sec_wrap & sec_sel;
    wire ev_min = min_wrap;

    // events that interrupt; level bit excluded
    wire [7:0] ev_set = {ev_min, ev_sec, ev_fsk, 1'b0, 2'b00, ev_tone, ev_pol};

    always_comb
    begin
        status_next = status_reg;
        status_next[ST_POL_A] = pol_a_now;
        status_next[ST_POL_B] = pol_b_now;
        status_next[ST_BATT] = battery_sense_input_i;
        if (!fsk_en)
        begin
            status_next[ST_BOM] = 1'b0;
            status_next[ST_OVR] = 1'b0;
            status_next[ST_FRM] = 1'b0;
        end
        else
        begin
            if (begin_of_marks_i)
                status_next[ST_BOM] = 1'b1;
            if (ev_fsk)
                status_next[ST_OVR] = overrun;
            if (rx_word_i.valid)
                status_next[ST_FRM] = word_bad;
        end
    end

    always_comb
    begin
        flag_next = flag_reg;
        if (int_read_i)
            flag_next = 8'h00;
        flag_next = flag_next | ev_set;
        if (lvl_sample)
            flag_next[IF_LOWLVL] = level_low_i;
    end

    always_comb
    begin
        ring_state_next = ring_state_reg;
        ring_next = ring_reg;
        meas_next = meas_reg;
        if (tick && !meas_sat)
            meas_next = meas_reg + 8'h01;
        case (ring_state_reg)
            RS_IDLE:
            begin
                if (ev_b)
                begin
                    ring_state_next = RS_B_SEEN;
                    ring_next = RING_RESET;
                    meas_next = 8'h00;
                end
            end
            RS_B_SEEN:
            begin
                if (ev_b)
                begin
                    ring_next = RING_RESET;
                    meas_next = 8'h00;
                end
                else if (ev_a)
                    ring_state_next = RS_A_SEEN;
            end
            RS_A_SEEN:
            begin
                if (ev_b)
                begin
                    ring_next = meas_sat ? RING_MAX : meas_reg;
                    ring_state_next = RS_B_SEEN;
                    meas_next = 8'h00;
                end
            end
            default:
                ring_state_next = RS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            status_reg <= 8'h00;
            flag_reg <= 8'h00;
            ring_reg <= RING_RESET;
            meas_reg <= 8'h00;
            ring_state_reg <= RS_IDLE;
            rx_data_reg <= 8'h00;
        end
        else
        begin
            status_reg <= status_next;
            flag_reg <= flag_next;
            ring_reg <= ring_next;
            meas_reg <= meas_next;
            ring_state_reg <= ring_state_next;
            if (ev_fsk)
                rx_data_reg <= rx_word_i.data;
        end
    end

    // free-running dividers; time base held reset when off
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tick_cnt_reg <= '0;
            lvl_cnt_reg <= 20'h00000;
            sec_cnt_reg <= 12'h000;
            min_cnt_reg <= 6'h00;
        end
        else
        begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TICK_W'(1);
            lvl_cnt_reg <= lvl_sample ? 20'h00000 : lvl_cnt_reg + 20'h00001;
            if (!tb_en)
            begin
                sec_cnt_reg <= 12'h000;
                min_cnt_reg <= 6'h00;
            end
            else if (tick)
            begin
                sec_cnt_reg <= sec_wrap ? 12'h000 : sec_cnt_reg + 12'h001;
                if (sec_wrap)
                    min_cnt_reg <= min_wrap ? 6'h00 : min_cnt_reg + 6'h01;
            end
        end
    end

    // tone detector init after reset or enable
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            init_cnt_reg <= INIT_MAX;
            tone_en_d_reg <= 1'b0;
            tone_init_busy_o <= 1'b1;
        end
        else
        begin
            tone_en_d_reg <= tone_en;
            if (tone_en && !tone_en_d_reg)
                init_cnt_reg <= INIT_MAX;
            else if (init_cnt_reg != '0)
                init_cnt_reg <= init_cnt_reg - INIT_W'(1);
            tone_init_busy_o <= (init_cnt_reg > INIT_W'(1)) || (tone_en && !tone_en_d_reg);
        end
    end

    // pin blanking: released at first read bit, kept off one serial clock
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            blank_reg <= 1'b0;
        else if (int_first_bit_i)
            blank_reg <= 1'b1;
        else if (serial_clk_rise_i)
            blank_reg <= 1'b0;
    end

    wire irq_active = (|flag_next[7:5] | |flag_next[1:0]) & ~int_first_bit_i
        & ~blank_reg;
    wire irq_low = mode_reg_one_i[MD1_IRQ_LOW];

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            irq_reg <= 1'b0;
            irq_oe_reg <= 1'b0;
        end
        else
        begin
            irq_oe_reg <= irq_active;
            irq_reg <= ~irq_low;
        end
    end

    assign status_o = status_reg;
    assign interrupt_flag_reg_o = flag_reg;
    assign ring_period_o = ring_reg;
    assign rx_data_o = rx_data_reg;
    assign irq_o = irq_reg;
    assign irq_oe_o = irq_oe_reg;
endmodule : cas_alert_status

// ---- test/cas_alert_status_chk.sv ----
// Purpose: port checker for cas_alert_status
// Assumes: status and flags lag their cause by one cycle
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module cas_alert_status_chk
    import cas_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // inputs watched
    input wire logic [7:0] mode_reg_one_i,
    input wire logic [7:0] mode_reg_two_i,
    input wire logic polarity_in_a_i,
    input wire logic polarity_in_b_i,
    input wire logic battery_sense_input_i,
    input wire cas_rx_word_t rx_word_i,
    input wire logic int_read_i,
    input wire logic int_first_bit_i,
    // outputs watched
    input wire logic [7:0] status_o,
    input wire logic [7:0] interrupt_flag_reg_o,
    input wire logic [7:0] rx_data_o,
    input wire logic irq_o,
    input wire logic irq_oe_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    batt_follow_a: assert property (1 |=>
        status_o[ST_BATT] == $past(battery_sense_input_i))
        else $error("battery flag wrong");
    pol_a_status_a: assert property (1 |=>
        status_o[ST_POL_A] == !$past(polarity_in_a_i))
        else $error("polarity a status wrong");
    pol_event_a: assert property ($rose(polarity_in_b_i) && mode_reg_one_i[MD1_POL_EN]
        |=> interrupt_flag_reg_o[IF_POL]) else $error("polarity b event lost");
    read_clear_a: assert property (int_read_i && !mode_reg_one_i[MD1_POL_EN]
        && !mode_reg_two_i[MD2_TB_EN] && !rx_word_i.valid
        |=> (interrupt_flag_reg_o & 8'hed) == 8'h00) else $error("flags not cleared");
    pin_level_a: assert property (irq_oe_o && $stable(mode_reg_one_i[MD1_IRQ_LOW])
        |-> irq_o != mode_reg_one_i[MD1_IRQ_LOW]) else $error("irq level wrong");
    pin_release_a: assert property (int_first_bit_i |=> !irq_oe_o)
        else $error("irq not released");
    word_load_a: assert property (rx_word_i.valid && rx_word_i.start_ok
        && rx_word_i.stop_ok
        && mode_reg_one_i[MD1_FSK_EN] && !mode_reg_one_i[MD1_BOM_MASK]
        |=> rx_data_o == $past(rx_word_i.data) && interrupt_flag_reg_o[IF_FSK])
        else $error("word not loaded");
    marks_off_a: assert property (!mode_reg_one_i[MD1_FSK_EN] |=> !status_o[ST_BOM])
        else $error("marks flag kept");
endmodule : cas_alert_status_chk
bind cas_alert_status cas_alert_status_chk u_cas_alert_status_chk (.mclk_i, .reset_i,
    .mode_reg_one_i, .mode_reg_two_i, .polarity_in_a_i, .polarity_in_b_i,
    .battery_sense_input_i, .rx_word_i, .int_read_i, .int_first_bit_i, .status_o,
    .interrupt_flag_reg_o, .rx_data_o, .irq_o, .irq_oe_o);

// ---- test/cas_host_model.sv ----
// Purpose: host side of the interrupt register read
// Assumes: one serial rising edge per pulse
// Notes: gap stretches each serial bit
`timescale 1ns/100ps
module cas_host_model
(
    // clock
    input wire logic mclk_i,
    // read strobes
    output logic int_read_o,
    output logic int_first_bit_o,
    output logic serial_clk_rise_o
);
    initial
    begin
        int_read_o = 1'b0;
        int_first_bit_o = 1'b0;
        serial_clk_rise_o = 1'b0;
    end
    task automatic read_flags(input int gap);
        for (int b = 0; b < 8; b++)
        begin
            @(negedge mclk_i);
            serial_clk_rise_o = 1'b1;
            int_first_bit_o = (b == 0);
            @(negedge mclk_i);
            serial_clk_rise_o = 1'b0;
            int_first_bit_o = 1'b0;
            repeat (gap) @(negedge mclk_i);
        end
        int_read_o = 1'b1;
        @(negedge mclk_i);
        int_read_o = 1'b0;
    endtask : read_flags
endmodule : cas_host_model

// ---- test/test_caller_alert_status_interrupt.sv ----
// Purpose: scenario bench for cas_alert_status
// Assumes: short counts, 4 cycles a tick
// Notes: inputs change on falling edges
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module test_caller_alert_status_interrupt
    import cas_pkg::*;
;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] mode_one, mode_two;
    logic pol_a, pol_b, batt, tone_en, tone_det;
    logic lvl_low, begin_of_marks;
    cas_rx_word_t word;
    logic rd, first, srise, irq, irq_oe, busy;
    logic [7:0] status, flags, ring, data;
    int miscompares = 0, check_count = 0;
    always #12.5 mclk_i = ~mclk_i;
    cas_alert_status #(.TICK_DIV(4), .LVL_DIV(16), .SEC_LEN(4)) u_cas_alert_status (
        .mclk_i(mclk_i), .reset_i(reset_i), .mode_reg_one_i(mode_one),
        .mode_reg_two_i(mode_two), .polarity_in_a_i(pol_a), .polarity_in_b_i(pol_b),
        .battery_sense_input_i(batt), .tone_enable_i(tone_en), .tone_detect_i(tone_det),
        .level_low_i(lvl_low), .begin_of_marks_i(begin_of_marks), .rx_word_i(word), .int_read_i(rd),
        .int_first_bit_i(first), .serial_clk_rise_i(srise), .status_o(status),
        .interrupt_flag_reg_o(flags), .ring_period_o(ring), .rx_data_o(data),
        .tone_init_busy_o(busy), .irq_o(irq), .irq_oe_o(irq_oe));
    cas_host_model u_cas_host_model (.mclk_i(mclk_i), .int_read_o(rd),
        .int_first_bit_o(first), .serial_clk_rise_o(srise));
    task automatic step(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : step
    task automatic send(input logic [7:0] d, input logic ok);
        word = '{valid: 1'b1, start_ok: 1'b1, stop_ok: ok, data: d};
        step(1);
        word = '0;
        step(1);
    endtask : send
    task automatic close_out;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic t_batt;
        batt = 1'b1;
        step(2);
        `CHK("batt", 2'b10, {status[ST_BATT], irq_oe})
        batt = 1'b0;
        step(2);
        `CHK("batt_clr", 1'b0, status[ST_BATT])
    endtask : t_batt
    task automatic t_ring;
        mode_one[MD1_POL_EN] = 1'b1;
        pol_b = 1'b1;
        step(3);
        `CHK("ring_1st", RING_RESET, ring)
        pol_b = 1'b0;
        pol_a = 1'b0;
        step(19);
        pol_a = 1'b1;
        step(58);
        pol_b = 1'b1;
        step(3);
        `CHK("ring_meas", 1'b1, ring inside {[8'd19:8'd21]})
        pol_b = 1'b0;
        pol_a = 1'b0;
        step(1100);
        pol_a = 1'b1;
        step(2);
        pol_b = 1'b1;
        step(3);
        `CHK("ring_sat", RING_MAX, ring)
        mode_one[MD1_POL_EN] = 1'b0;
        pol_b = 1'b0;
        u_cas_host_model.read_flags(1);
    endtask : t_ring
    task automatic t_pol;
        pol_b = 1'b1;
        step(3);
        `CHK("st_b", 2'b10, {status[ST_POL_B], flags[IF_POL]})
        mode_one[MD1_POL_EN] = 1'b1;
        pol_a = 1'b0;
        step(2);
        `CHK("st_a", 1'b1, status[ST_POL_A])
        pol_a = 1'b1;
        step(3);
        `CHK("pol_a_ev", 3'b111, {flags[IF_POL], irq_oe, irq})
        mode_one[MD1_IRQ_LOW] = 1'b1;
        step(2);
        `CHK("irq_lo", 2'b10, {irq_oe, irq})
        fork
            u_cas_host_model.read_flags(2);
            begin
                // off after the first bit, back one serial clock later
                step(3);
                `CHK("irq_off", 1'b0, irq_oe)
                step(4);
                `CHK("irq_back", 1'b1, irq_oe)
            end
        join
        step(1);
        `CHK("rd_clr", 9'h000, {flags, irq_oe})
        pol_b = 1'b0;
        fork
            u_cas_host_model.read_flags(0);
            begin
                step(16);
                pol_b = 1'b1;
            end
        join
        step(1);
        `CHK("kept", 1'b1, flags[IF_POL])
        mode_one = 8'h00;
        u_cas_host_model.read_flags(1);
    endtask : t_pol
    task automatic t_fsk;
        mode_one = 8'hc0;
        send(8'h5a, 1'b1);
        `CHK("pre_bom", 1'b0, flags[IF_FSK])
        begin_of_marks = 1'b1;
        step(1);
        begin_of_marks = 1'b0;
        step(1);
        `CHK("bom", 1'b1, status[ST_BOM])
        send(8'ha5, 1'b1);
        `CHK("word", 10'h3a5, {flags[IF_FSK], irq_oe, data})
        send(8'h3c, 1'b1);
        `CHK("ovr", 1'b1, status[ST_OVR])
        send(8'h0f, 1'b0);
        `CHK("frm", 1'b1, status[ST_FRM])
        mode_one = 8'h00;
        step(2);
        `CHK("bom_off", 1'b0, status[ST_BOM])
        u_cas_host_model.read_flags(1);
        mode_one = 8'h80;
        send(8'h55, 1'b1);
        `CHK("no_mask", 9'h155, {flags[IF_FSK], data})
        mode_one = 8'h00;
        u_cas_host_model.read_flags(1);
    endtask : t_fsk
    task automatic t_tone;
        int n;
        n = 0;
        mode_two[MD2_SYSCLK_EN] = 1'b1;
        tone_en = 1'b1;
        step(2);
        while (busy === 1'b1 && n < INIT_CYC)
        begin
            step(1);
            n++;
        end
        `CHK("init", 1'b0, busy)
        lvl_low = 1'b1;
        step(40);
        `CHK("lvl", 2'b10, {flags[IF_LOWLVL], irq_oe})
        tone_det = 1'b1;
        step(1);
        tone_det = 1'b0;
        step(2);
        `CHK("tone_low", 1'b0, flags[IF_TONE])
        lvl_low = 1'b0;
        step(40);
        tone_det = 1'b1;
        step(1);
        tone_det = 1'b0;
        step(2);
        `CHK("tone", 2'b11, {flags[IF_TONE], irq_oe})
        tone_en = 1'b0;
        u_cas_host_model.read_flags(1);
        mode_two[MD2_SYSCLK_EN] = 1'b0;
        step(1);
        `CHK("pd_clr", 8'h00, flags)
    endtask : t_tone
    task automatic t_time;
        mode_two = 8'h60;
        step(24);
        `CHK("sec", 1'b1, flags[IF_SEC])
        mode_two = 8'h40;
        u_cas_host_model.read_flags(1);
        step(1000);
        `CHK("min", 2'b10, flags[IF_MIN:IF_SEC])
        mode_two = 8'h00;
        u_cas_host_model.read_flags(1);
        step(1000);
        `CHK("tb_off", 2'b00, flags[IF_MIN:IF_SEC])
    endtask : t_time
    initial
    begin
        mode_one = 8'h00;
        mode_two = 8'h00;
        pol_a = 1'b1;
        pol_b = 1'b0;
        batt = 1'b0;
        tone_en = 1'b0;
        tone_det = 1'b0;
        lvl_low = 1'b0;
        begin_of_marks = 1'b0;
        word = '0;
        step(5);
        `CHK("rst", 9'h1ff, {busy, ring})
        step(1);
        reset_i = 1'b0;
        step(2);
        t_batt();
        t_ring();
        t_pol();
        t_fsk();
        t_tone();
        t_time();
        close_out();
    end
    initial
    begin
        #500000;
        miscompares++;
        close_out();
    end
endmodule : test_caller_alert_status_interrupt
